// file: core/serial_link_map.vh
// Purpose: shared constants of the serial link endpoint
// Assumes: bit clock is core_clk; one character is ten bit clocks
// Notes: codes are written first-bit-in-msb (abcdei fghj)
`ifndef SERIAL_LINK_MAP_VH
`define SERIAL_LINK_MAP_VH

`define BITS_PER_CHAR      4'ha
`define BYTE_CLK_HIGH      4'h5
`define STROBE_LOW_PCT     60
`define STROBE_LOW_CYCLES  ((10 * `STROBE_LOW_PCT) / 100)
`define COMMA_RDN          10'h0fa
`define COMMA_RDP          10'h305
`define VIOLATION_CODE     10'h3c2
`define VIOLATION_REQ_BYTE 8'he0
`define PAD_BYTE           8'hbc
`define K28_SIX_RDN        6'h0f
`define K28_SIX_RDP        6'h30
`define K28_X              5'h1c
`define ALT7_RDN           4'h7
`define ALT7_RDP           4'h8

`endif

// file: core/duty_strobe.v
// Purpose: active-low strobe, low for a fixed count after a start pulse
// Assumes: start comes at most once per character period
// Notes: high for the rest of the character period
`timescale 1ns/1ps
module duty_strobe #(
  parameter LOW_CYCLES = 6
) (
  input  wire core_clk,
  input  wire rst,
  input  wire start,
  output reg  strobeN
);
  reg [3:0] lowLeft_q;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lowLeft_q <= 4'h0;
      strobeN   <= 1'b1;
    end else if (start) begin
      lowLeft_q <= LOW_CYCLES[3:0] - 4'h1;
      strobeN   <= 1'b0;
    end else if (lowLeft_q != 4'h0) begin
      lowLeft_q <= lowLeft_q - 4'h1;
      strobeN   <= 1'b0;
    end else begin
      strobeN   <= 1'b1;
    end
  end
endmodule // duty_strobe

// file: core/serial_link_endpoint.v
// Purpose: 8b/10b serial link transmitter and receiver datapath
// Assumes: core_clk is the bit clock; parallel side is clocked by our byte clocks
// Notes: no clock recovery; the serial input is sampled once per bit clock
//
// Functional notes
// - capture input when either load strobe low
// - read pulse low 60%, high 40%
// - bit clock ten times byte clock
// - transmit latency about 21 bit times
// - receive byte clock is bit clock/10
// - receive latency about 24 bit times
// - ready pulses low 60% per character
// - no ready inside a run of commas, except the one the framer finds
// - bypass: ready pulses on any comma
// - framer request sampled on byte clock fall
// - found comma realigns later byte boundaries
// - ready held high while framer searches
// - context bit selects data or special code
// - C0.7 or violation request sends violation
// - bypass sends ten-bit word unchanged
// - input register to shifter, then serial
// - no strobe means K28.5 pad character
// - all three serial pairs carry same data
// - shutoff forces pairs A, B low
// - framer inhibited while request low
// - receiver outputs byte, context, violation
`timescale 1ns/1ps
`include "serial_link_map.vh"
module serial_link_endpoint (
  input  wire       core_clk,
  input  wire       rst,
  input  wire [7:0] txByteIn,
  input  wire       specialCharFlagIn,
  input  wire       sendViolation,
  input  wire       loadStrobeFirstN,
  input  wire       loadStrobeSecondN,
  input  wire       txBypassMode,
  input  wire       opticalShutoff,
  output reg        byteWriteClock,
  output wire       readPulseN,
  output reg        serialOutAP,
  output reg        serialOutAN,
  output reg        serialOutBP,
  output reg        serialOutBN,
  output reg        serialOutCP,
  output reg        serialOutCN,
  input  wire       serialInPairs,
  input  wire       framerRequest,
  input  wire       rxBypassMode,
  output reg        recoveredByteClock,
  output reg  [7:0] rxByteOut,
  output reg        specialCharFlagOut,
  output reg        violationDetected,
  output wire       readyN
);

  // 5b/6b table, negative running disparity form
  function [5:0] six;
    input [4:0] x;
    begin
      case (x)
        5'd0:  six = 6'b100111;  5'd1:  six = 6'b011101;
        5'd2:  six = 6'b101101;  5'd3:  six = 6'b110001;
        5'd4:  six = 6'b110101;  5'd5:  six = 6'b101001;
        5'd6:  six = 6'b011001;  5'd7:  six = 6'b111000;
        5'd8:  six = 6'b111001;  5'd9:  six = 6'b100101;
        5'd10: six = 6'b010101;  5'd11: six = 6'b110100;
        5'd12: six = 6'b001101;  5'd13: six = 6'b101100;
        5'd14: six = 6'b011100;  5'd15: six = 6'b010111;
        5'd16: six = 6'b011011;  5'd17: six = 6'b100011;
        5'd18: six = 6'b010011;  5'd19: six = 6'b110010;
        5'd20: six = 6'b001011;  5'd21: six = 6'b101010;
        5'd22: six = 6'b011010;  5'd23: six = 6'b111010;
        5'd24: six = 6'b110011;  5'd25: six = 6'b100110;
        5'd26: six = 6'b010110;  5'd27: six = 6'b110110;
        5'd28: six = 6'b001110;  5'd29: six = 6'b101110;
        5'd30: six = 6'b011110;  default: six = 6'b101011;
      endcase
    end
  endfunction

  // 3b/4b table, negative running disparity form
  function [3:0] four;
    input [2:0] y;
    begin
      case (y)
        3'd0: four = 4'b1011;  3'd1: four = 4'b1001;
        3'd2: four = 4'b0101;  3'd3: four = 4'b1100;
        3'd4: four = 4'b1101;  3'd5: four = 4'b1010;
        3'd6: four = 4'b0110;  default: four = 4'b1110;
      endcase
    end
  endfunction

  function unbal6;
    input [5:0] c;
    begin
      unbal6 = ({2'b00, c[0]} + c[1] + c[2] + c[3] + c[4] + c[5]) != 3'd3;
    end
  endfunction

  function unbal4;
    input [3:0] c;
    begin
      unbal4 = ({1'b0, c[0]} + c[1] + c[2] + c[3]) != 2'd2;
    end
  endfunction

  function altX;
    input [4:0] x;
    begin
      altX = (x == 5'd23) || (x == 5'd27) || (x == 5'd29) || (x == 5'd30);
    end
  endfunction

  // returns {next disparity, code}; disparity 1 = positive
  function [10:0] encode;
    input [7:0] d;
    input       k;
    input       rd;
    reg   [5:0] c6;
    reg   [3:0] c4;
    reg         rd6;
    reg         k28;
    reg         alt;
    reg         u4;
    reg         comp4;
    begin
      k28 = k && (d[4:0] == `K28_X);
      c6  = k28 ? `K28_SIX_RDN : six(d[4:0]);
      rd6 = rd ^ unbal6(c6);
      if (rd && (unbal6(c6) || (d[4:0] == 5'd7 && !k28)))
        c6 = ~c6;
      alt = (d[7:5] == 3'd7) && (k ||
            (!rd6 && (d[4:0] == 5'd17 || d[4:0] == 5'd18 || d[4:0] == 5'd20)) ||
            (rd6 && (d[4:0] == 5'd11 || d[4:0] == 5'd13 || d[4:0] == 5'd14)));
      c4  = alt ? `ALT7_RDN : four(d[7:5]);
      u4  = unbal4(c4);
      comp4 = (u4 || d[7:5] == 3'd3) ? rd6 : (k28 && !rd6);
      if (comp4)
        c4 = ~c4;
      encode = {rd6 ^ u4, c6, c4};
    end
  endfunction

  // returns {violation, context, byte}
  function [9:0] decode;
    input [9:0] c;
    reg   [5:0] c6;
    reg   [3:0] c4;
    reg   [4:0] x;
    reg   [2:0] y;
    reg         hit6;
    reg         hit4;
    reg         k28;
    reg         alt;
    integer     i;
    begin
      c6   = c[9:4];
      c4   = c[3:0];
      x    = 5'd0;
      y    = 3'd0;
      hit6 = 1'b0;
      hit4 = 1'b0;
      alt  = 1'b0;
      k28  = (c6 == `K28_SIX_RDN) || (c6 == `K28_SIX_RDP);
      if (k28) begin
        x    = `K28_X;
        hit6 = 1'b1;
        if (c6 == `K28_SIX_RDP && !unbal4(c4) && c4 != 4'b1100 && c4 != 4'b0011)
          c4 = ~c4;
      end
      for (i = 0; i < 32; i = i + 1) begin
        if (c6 == six(i[4:0]) ||
            (c6 == ~six(i[4:0]) && (unbal6(six(i[4:0])) || i == 7))) begin
          x    = i[4:0];
          hit6 = 1'b1;
        end
      end
      for (i = 0; i < 8; i = i + 1) begin
        if (c4 == four(i[2:0]) ||
            (c4 == ~four(i[2:0]) && (unbal4(four(i[2:0])) || i == 3))) begin
          y    = i[2:0];
          hit4 = 1'b1;
        end
      end
      if (c4 == `ALT7_RDN || c4 == `ALT7_RDP) begin
        y    = 3'd7;
        hit4 = 1'b1;
        alt  = 1'b1;
      end
      decode = {!(hit6 && hit4), k28 || (alt && altX(x)), y, x};
    end
  endfunction

  // input synchronisers for pins outside the bit clock domain
  reg [1:0] shutoffSync_q;
  reg [1:0] serialSync_q;
  reg [1:0] framerSync_q;
  reg [1:0] txModeSync_q;
  reg [1:0] rxModeSync_q;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shutoffSync_q <= 2'b00;
      serialSync_q  <= 2'b00;
      framerSync_q  <= 2'b00;
      txModeSync_q  <= 2'b00;
      rxModeSync_q  <= 2'b00;
    end else begin
      shutoffSync_q <= {shutoffSync_q[0], opticalShutoff};
      serialSync_q  <= {serialSync_q[0], serialInPairs};
      framerSync_q  <= {framerSync_q[0], framerRequest};
      txModeSync_q  <= {txModeSync_q[0], txBypassMode};
      rxModeSync_q  <= {rxModeSync_q[0], rxBypassMode};
    end
  end

  // transmitter
  reg  [3:0] txCnt_q;
  reg  [7:0] txByte_q;
  reg        txCtx_q;
  reg        txViol_q;
  reg        txValid_q;
  reg        txRd_q;
  reg  [9:0] txShift_q;
  reg  [9:0] txWord;
  reg        txRdNext;
  reg [10:0] txEnc;
  wire       txByteEn = (txCnt_q == `BITS_PER_CHAR - 4'h1);
  wire [3:0] txCnt_d  = txByteEn ? 4'h0 : txCnt_q + 4'h1;
  wire       txLoad   = !loadStrobeFirstN || !loadStrobeSecondN;

  always @* begin
    txEnc    = encode(txValid_q ? txByte_q : `PAD_BYTE, txValid_q ? txCtx_q : 1'b1, txRd_q);
    txWord   = txEnc[9:0];
    txRdNext = txEnc[10];
    if (!txValid_q) begin
      txWord   = txEnc[9:0];
    end else if (txModeSync_q[1]) begin
      txWord   = {txCtx_q, txByte_q, txViol_q};
      txRdNext = txRd_q;
    end else if (txViol_q || (txCtx_q && txByte_q == `VIOLATION_REQ_BYTE) ||
                 (txCtx_q && txByte_q[4:0] != `K28_X &&
                  !(txByte_q[7:5] == 3'd7 && altX(txByte_q[4:0])))) begin
      txWord   = `VIOLATION_CODE;
      txRdNext = txRd_q;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txCnt_q        <= 4'h0;
      byteWriteClock <= 1'b1;
      txByte_q       <= 8'h00;
      txCtx_q        <= 1'b0;
      txViol_q       <= 1'b0;
      txValid_q      <= 1'b0;
      txRd_q         <= 1'b0;
      txShift_q      <= `COMMA_RDN;
    end else begin
      txCnt_q        <= txCnt_d;
      byteWriteClock <= (txCnt_d < `BYTE_CLK_HIGH);
      if (txByteEn) begin
        txValid_q <= txLoad;
        if (txLoad) begin
          txByte_q <= txByteIn;
          txCtx_q  <= specialCharFlagIn;
          txViol_q <= sendViolation;
        end
        txShift_q <= txWord;
        txRd_q    <= txRdNext;
      end else begin
        txShift_q <= {txShift_q[8:0], 1'b0};
      end
    end
  end

  // first bit leaves one clock after the shifter loads
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      serialOutAP <= 1'b0;
      serialOutAN <= 1'b1;
      serialOutBP <= 1'b0;
      serialOutBN <= 1'b1;
      serialOutCP <= 1'b0;
      serialOutCN <= 1'b1;
    end else begin
      serialOutAP <= txShift_q[9] && !shutoffSync_q[1];
      serialOutAN <= !(txShift_q[9] && !shutoffSync_q[1]);
      serialOutBP <= txShift_q[9] && !shutoffSync_q[1];
      serialOutBN <= !(txShift_q[9] && !shutoffSync_q[1]);
      serialOutCP <= txShift_q[9];
      serialOutCN <= !txShift_q[9];
    end
  end

  duty_strobe #(
    .LOW_CYCLES (`STROBE_LOW_CYCLES)
  ) readPulseGen (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (txByteEn && !loadStrobeFirstN),
    .strobeN  (readPulseN)
  );

  // receiver; a comma seen while framing restarts the character count
  reg  [9:0] rxShift_q;
  reg  [3:0] rxCnt_q;
  reg  [9:0] rxDec_q;
  reg        framerEn_q;
  reg        searching_q;
  reg        foundMark_q;
  reg        rdyStart_q;
  wire [9:0] rxWindow = {rxShift_q[8:0], serialSync_q[1]};
  wire       windowComma = (rxWindow == `COMMA_RDN) || (rxWindow == `COMMA_RDP);
  wire       decComma    = (rxDec_q == `COMMA_RDN) || (rxDec_q == `COMMA_RDP);
  wire       frameHit = framerEn_q && windowComma;
  wire       rxCapture = frameHit || (rxCnt_q == `BITS_PER_CHAR - 4'h1);
  wire [3:0] rxCnt_d  = rxCapture ? 4'h0 : rxCnt_q + 4'h1;
  wire [9:0] rxDecoded = decode(rxDec_q);
  wire       byteClkFall = recoveredByteClock && !(rxCnt_d < `BYTE_CLK_HIGH);
  // outside rx bypass, a run of commas only shows ready on its last member and on a comma the framer finds; in bypass every comma does
  wire       normalRdy = rxModeSync_q[1] ? decComma : !(decComma && windowComma);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxShift_q          <= 10'h000;
      rxCnt_q            <= 4'h0;
      rxDec_q            <= `COMMA_RDN;
      recoveredByteClock <= 1'b1;
      rxByteOut          <= 8'h00;
      specialCharFlagOut <= 1'b0;
      violationDetected  <= 1'b0;
      framerEn_q         <= 1'b0;
      searching_q        <= 1'b0;
      foundMark_q        <= 1'b0;
      rdyStart_q         <= 1'b0;
    end else begin
      rxShift_q          <= rxWindow;
      rxCnt_q            <= rxCnt_d;
      recoveredByteClock <= (rxCnt_d < `BYTE_CLK_HIGH);
      if (byteClkFall) begin
        framerEn_q <= framerSync_q[1];
        if (framerSync_q[1] && !framerEn_q)
          searching_q <= 1'b1;
      end
      rdyStart_q <= 1'b0;
      if (rxCapture) begin
        rxDec_q <= rxWindow;
        if (rxModeSync_q[1]) begin
          {specialCharFlagOut, rxByteOut, violationDetected} <= rxDec_q;
        end else begin
          violationDetected  <= rxDecoded[9];
          specialCharFlagOut <= rxDecoded[8];
          rxByteOut          <= rxDecoded[7:0];
        end
        // mark is one-shot, else a comma run would get a second ready
        if (foundMark_q) begin
          rdyStart_q  <= 1'b1;
          searching_q <= 1'b0;
          foundMark_q <= 1'b0;
        end else begin
          rdyStart_q  <= !searching_q && normalRdy;
          foundMark_q <= frameHit && searching_q;
        end
      end
    end
  end

  duty_strobe #(
    .LOW_CYCLES (`STROBE_LOW_CYCLES)
  ) readyGen (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (rdyStart_q),
    .strobeN  (readyN)
  );

endmodule // serial_link_endpoint

// file: verif/serial_link_endpoint_sva.sv
// Purpose: port-level timing checks of the link endpoint
// Assumes: single bit clock, async high reset
// Notes: shutoff passes a 2-stage sync, so its effect is judged 4 cycles on
`timescale 1ns/1ps
module serial_link_endpoint_sva (
  input wire core_clk,
  input wire rst,
  input wire loadStrobeFirstN,
  input wire opticalShutoff,
  input wire byteWriteClock,
  input wire readPulseN,
  input wire serialOutAP,
  input wire serialOutAN,
  input wire serialOutBP,
  input wire serialOutBN,
  input wire serialOutCP,
  input wire serialOutCN,
  input wire recoveredByteClock,
  input wire readyN
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  pairs_compl_a: assert property (serialOutAN == !serialOutAP && serialOutBN == !serialOutBP
    && serialOutCN == !serialOutCP) else $error("serial pair not complementary");
  same_data_a: assert property (!opticalShutoff && !$past(opticalShutoff)
    && !$past(opticalShutoff, 2) && !$past(opticalShutoff, 3) && !$past(opticalShutoff, 4)
    |-> serialOutAP == serialOutCP && serialOutBP == serialOutCP) else $error("pairs differ");
  shut_off_a: assert property (opticalShutoff && $past(opticalShutoff)
    && $past(opticalShutoff, 2) && $past(opticalShutoff, 3) && $past(opticalShutoff, 4)
    |-> !serialOutAP && !serialOutBP) else $error("pairs A B not forced low");
  byte_clk_a: assert property ($rose(byteWriteClock)
    |-> byteWriteClock[*5] ##1 !byteWriteClock[*5]) else $error("byte clock not 5/5");
  rx_clk_a: assert property ($rose(recoveredByteClock)
    |-> recoveredByteClock[*5]) else $error("rx byte clock high too short");
  ready_align_a: assert property ($fell(readyN) |-> recoveredByteClock
    && $past(recoveredByteClock) && !$past(recoveredByteClock, 2)) else $error("ready misaligned");
  ready_duty_a: assert property ($fell(readyN)
    |-> !readyN[*6] ##1 readyN) else $error("ready low width wrong");
  read_duty_a: assert property ($fell(readPulseN)
    |-> !readPulseN[*6] ##1 readPulseN[*4]) else $error("read pulse not 6/4");
  read_cause_a: assert property ($rose(byteWriteClock) && !$past(loadStrobeFirstN)
    |-> ##[0:2] !readPulseN) else $error("read pulse missing");
  no_read_a: assert property ($rose(byteWriteClock) && $past(loadStrobeFirstN)
    |-> readPulseN[*6]) else $error("read pulse without first strobe");
endmodule // serial_link_endpoint_sva

bind serial_link_endpoint serial_link_endpoint_sva chk (.core_clk(core_clk), .rst(rst),
  .loadStrobeFirstN(loadStrobeFirstN), .opticalShutoff(opticalShutoff),
  .byteWriteClock(byteWriteClock), .readPulseN(readPulseN), .serialOutAP(serialOutAP),
  .serialOutAN(serialOutAN), .serialOutBP(serialOutBP), .serialOutBN(serialOutBN),
  .serialOutCP(serialOutCP), .serialOutCN(serialOutCN),
  .recoveredByteClock(recoveredByteClock), .readyN(readyN));

// file: verif/link_ctrl_model.sv
// Purpose: far-side controller feeding the transmitter parallel inputs
// Assumes: inputs are captured at the edge where byteWriteClock rises
// Notes: entry is {useSecond, ctx, byte, viol}; idle lines wander, never hold
`timescale 1ns/1ps
module link_ctrl_model (
  input  wire       core_clk,
  input  wire       byteWriteClock,
  output reg  [7:0] txByteIn,
  output reg        specialCharFlagIn,
  output reg        sendViolation,
  output reg        loadStrobeFirstN,
  output reg        loadStrobeSecondN
);
  reg [10:0] pending [$];
  reg [10:0] w;
  reg        clkPrev;

  task put(input [10:0] e);
    pending.push_back(e);
  endtask

  initial begin
    {specialCharFlagIn, txByteIn, sendViolation} = 10'h000;
    {loadStrobeFirstN, loadStrobeSecondN} = 2'b11;
    clkPrev = 1'b1;
  end

  // change just after the capture edge so the value holds a whole character
  always @(negedge core_clk) begin
    if (byteWriteClock && !clkPrev) begin
      if (pending.size() > 0) begin
        w = pending.pop_front();
        {specialCharFlagIn, txByteIn, sendViolation} <= w[9:0];
        loadStrobeFirstN  <= w[10];
        loadStrobeSecondN <= !w[10];
      end else begin
        {specialCharFlagIn, txByteIn, sendViolation} <= ~{specialCharFlagIn, txByteIn,
          sendViolation};
        {loadStrobeFirstN, loadStrobeSecondN} <= 2'b11;
      end
    end
    clkPrev <= byteWriteClock;
  end
endmodule // link_ctrl_model

// file: verif/serial_link_endpoint_tb.sv
// Purpose: loopback bench of the link endpoint, pair C fed back to the receiver
// Assumes: 20 MHz bit clock, inputs driven on the falling edge
// Notes: rx characters are logged at each ready fall as {ctx, byte, viol}
`timescale 1ns/1ps
`include "serial_link_map.vh"
module serial_link_endpoint_tb;
  reg        core_clk, rst, txBypassMode, opticalShutoff, framerRequest, rxBypassMode;
  wire [7:0] txByteIn, rxByteOut;
  wire       specialCharFlagIn, sendViolation, loadStrobeFirstN, loadStrobeSecondN;
  wire       byteWriteClock, readPulseN, recoveredByteClock, specialCharFlagOut;
  wire       serialOutAP, serialOutAN, serialOutBP, serialOutBN, serialOutCP, serialOutCN;
  wire       violationDetected, readyN;
  reg  [9:0] rxQ [$];
  reg        rdyPrev = 1'b1;
  reg        seenWord = 1'b0;
  int        n_errors, checks, i;

  serial_link_endpoint dut (.core_clk(core_clk), .rst(rst), .txByteIn(txByteIn),
    .specialCharFlagIn(specialCharFlagIn), .sendViolation(sendViolation),
    .loadStrobeFirstN(loadStrobeFirstN), .loadStrobeSecondN(loadStrobeSecondN),
    .txBypassMode(txBypassMode), .opticalShutoff(opticalShutoff),
    .byteWriteClock(byteWriteClock), .readPulseN(readPulseN), .serialOutAP(serialOutAP),
    .serialOutAN(serialOutAN), .serialOutBP(serialOutBP), .serialOutBN(serialOutBN),
    .serialOutCP(serialOutCP), .serialOutCN(serialOutCN), .serialInPairs(serialOutCP),
    .framerRequest(framerRequest), .rxBypassMode(rxBypassMode),
    .recoveredByteClock(recoveredByteClock), .rxByteOut(rxByteOut),
    .specialCharFlagOut(specialCharFlagOut), .violationDetected(violationDetected),
    .readyN(readyN));

  link_ctrl_model ctrl (.core_clk(core_clk), .byteWriteClock(byteWriteClock),
    .txByteIn(txByteIn), .specialCharFlagIn(specialCharFlagIn), .sendViolation(sendViolation),
    .loadStrobeFirstN(loadStrobeFirstN), .loadStrobeSecondN(loadStrobeSecondN));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(negedge core_clk) begin
    if (!readyN && rdyPrev) rxQ.push_back({specialCharFlagOut, rxByteOut, violationDetected});
    if (rxBypassMode && {specialCharFlagOut, rxByteOut, violationDetected} === 10'h155)
      seenWord <= 1'b1;
    rdyPrev <= readyN;
  end

  task check(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task test_reset;
    check({readyN, readPulseN, byteWriteClock, recoveredByteClock}, 10'h00f);
    check({serialOutAP, serialOutAN, serialOutCP, serialOutCN}, 10'h005);
  endtask

  task test_encoded;
    // unframed, the loop delay leaves the receiver off the character boundary
    repeat (100) @(negedge core_clk);
    check(10'(rxQ.size() > 5 && rxQ[$] !== {1'b1, `PAD_BYTE, 1'b0}), 10'h001);
    rxQ.delete();
    framerRequest = 1'b1;
    repeat (300) @(negedge core_clk);
    check(10'(rxQ.size() > 0), 10'h001);
    check(rxQ[$], {1'b1, `PAD_BYTE, 1'b0});
    rxQ.delete();
    ctrl.put({2'b00, 8'h00, 1'b0});
    ctrl.put({2'b10, 8'h5a, 1'b0});
    ctrl.put({2'b00, 8'hff, 1'b0});
    ctrl.put({2'b01, 8'h3c, 1'b0});
    ctrl.put({2'b01, `VIOLATION_REQ_BYTE, 1'b0});
    ctrl.put({2'b00, 8'h12, 1'b1});
    repeat (300) @(negedge core_clk);
    check(10'(rxQ.size()), 10'h007);
    check(rxQ[0], {1'b1, `PAD_BYTE, 1'b0});
    check(rxQ[1], 10'h000);
    check(rxQ[2], {1'b0, 8'h5a, 1'b0});
    check(rxQ[3], {1'b0, 8'hff, 1'b0});
    check(rxQ[4], {1'b1, 8'h3c, 1'b0});
    check(10'(rxQ[5][0]), 10'h001);
    check(10'(rxQ[6][0]), 10'h001);
  endtask

  task test_shutoff;
    logic seenHigh, seenLow;
    seenHigh = 1'b0;
    seenLow = 1'b0;
    opticalShutoff = 1'b1;
    repeat (6) @(negedge core_clk);
    repeat (20) begin
      @(negedge core_clk);
      check({serialOutAP, serialOutAN, serialOutBP, serialOutBN}, 10'h005);
      if (serialOutCP === 1'b1) seenHigh = 1'b1;
      if (serialOutCP === 1'b0) seenLow = 1'b1;
    end
    check({seenHigh, seenLow}, 10'h003);
    opticalShutoff = 1'b0;
  endtask

  task test_bypass;
    txBypassMode = 1'b1;
    rxBypassMode = 1'b1;
    repeat (60) @(negedge core_clk);
    rxQ.delete();
    // alternating words keep transitions dense for the receiver
    for (i = 0; i < 6; i++) ctrl.put({1'b0, (i == 3) ? `COMMA_RDP : 10'h155});
    repeat (200) @(negedge core_clk);
    check(10'(rxQ.size() > 8), 10'h001);
    check(10'(seenWord), 10'h001);
    foreach (rxQ[j]) check(10'(rxQ[j] === `COMMA_RDN || rxQ[j] === `COMMA_RDP), 10'h001);
  endtask

  initial begin
    rst = 1'b1;
    txBypassMode = 1'b0;
    rxBypassMode = 1'b0;
    opticalShutoff = 1'b0;
    framerRequest = 1'b0;
    repeat (8) @(negedge core_clk);
    test_reset;
    rst = 1'b0;
    test_encoded;
    test_shutoff;
    test_bypass;
    stop_test;
  end

  // whole run is near 1000 cycles; four times that means a hang
  initial begin
    #200000;
    n_errors++;
    stop_test;
  end
endmodule // serial_link_endpoint_tb
